//--- logic/elpc_pkg.sv
/*
 * elpc_pkg: constants and state types for the error log and phy event
 * counter block.
 * Assumes: a 32-bit AHB-Lite register bus and one 250 MHz device clock.
 */
package elpc_pkg;

    // byte offsets on the register bus
    localparam logic [11:0] ELPC_ERR_PAGE_BASE = 12'h000;
    localparam logic [11:0] ELPC_EVT_PAGE_BASE = 12'h200;
    localparam logic [11:0] ELPC_CTRL_OFS = 12'h400;
    localparam logic [11:0] ELPC_STATUS_OFS = 12'h404;

    // log page layout
    localparam int ELPC_PAGE_BYTES = 512;
    localparam logic [6:0] ELPC_CKS_WORD = 7'h7F;
    localparam int ELPC_ERR_USED_BYTES = 14;
    localparam int ELPC_EVT_USED_BYTES = 28;
    localparam int ELPC_TAG_LSB = 0;
    localparam int ELPC_TAG_W = 5;
    localparam int ELPC_NQ_BIT = 7;

    // identifier word: width code in bits 14:12, counter code in 11:0
    localparam int ELPC_ID_WCODE_LSB = 12;
    localparam logic [2:0] ELPC_WCODE_16 = 3'h1;
    localparam int ELPC_NUM_CNT = 5;
    localparam int ELPC_CNT_W = 16;
    localparam logic [11:0] ELPC_ID_INTERFACE_CRC_ERROR = 12'h001;
    localparam logic [11:0] ELPC_ID_PHY_DROP = 12'h009;
    localparam logic [11:0] ELPC_ID_SIG_FIS = 12'h00A;
    localparam logic [11:0] ELPC_ID_RX_CRC = 12'h00B;
    localparam logic [11:0] ELPC_ID_RX_OTHER = 12'h00D;
    localparam logic [11:0] ELPC_ID_END = 12'h000;

    // control and status fields
    localparam int ELPC_CTRL_CLR_ON_READ = 0;
    localparam int ELPC_STAT_ERR_VALID = 0;
    localparam int ELPC_STAT_PHY_READY = 1;
    localparam int ELPC_STAT_CLR_ARMED = 2;

    // reset values
    localparam logic [31:0] ELPC_RDATA_RST = 32'h0000_0000;
    localparam logic [127:0] ELPC_ERR_REC_RST = 128'h0;

    typedef struct packed {
        logic pend;
        logic pend_wr;
        logic [9:0] pend_word;
        logic [31:0] rdata;
        logic ready;
        logic resp;
        logic clr_on_read;
        logic clr;
        logic phy_rdy;
        logic err_valid;
        logic [127:0] err_rec;
    } elpc_top_s;

endpackage : elpc_pkg

//--- logic/elpc_sat_cnt.sv
/*
 * elpc_sat_cnt: one saturating event counter with synchronous clear.
 * Assumes: inc and clr come from logic on the same clock.
 */
`timescale 1ns/1ps
module elpc_sat_cnt #(
    parameter int W = 16
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clr,
    input wire logic inc,
    output logic [W-1:0] cnt
);

    typedef struct packed {
        logic [W-1:0] cnt;
    } elpc_cnt_s;

    elpc_cnt_s s_q;
    elpc_cnt_s s_d;

    always_comb begin
        s_d = s_q;
        if (clr) begin
            // an event in the clearing cycle still counts once
            s_d.cnt = inc ? {{(W-1){1'b0}}, 1'b1} : '0;
        end else if (inc && s_q.cnt != {W{1'b1}}) begin
            s_d.cnt = s_q.cnt + {{(W-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign cnt = s_q.cnt;

    a_sat_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        (s_q.cnt == {W{1'b1}} && !clr) |=> s_q.cnt == {W{1'b1}})
        else $error("saturated counter moved");

    a_clr_zero: assert property (@(posedge hclk) disable iff (!hresetn)
        (clr && !inc) |=> s_q.cnt == '0)
        else $error("counter not cleared");

endmodule : elpc_sat_cnt

//--- logic/elpc_top.sv
/*
 * elpc_top: builds the queued-command error page and the phy event counter
 * page, both readable word by word over an AHB-Lite slave port.
 * Assumes: hresetn is asserted only at power-up; all event inputs are
 * one-cycle pulses or levels from logic on hclk; the master does single
 * word transfers.
 */
`timescale 1ns/1ps
module elpc_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic err_report,
    input wire logic non_queued_flag,
    input wire logic [4:0] err_tag,
    input wire logic [7:0] sh_status,
    input wire logic [7:0] sh_error,
    input wire logic [7:0] sh_lba_low,
    input wire logic [7:0] sh_lba_mid,
    input wire logic [7:0] sh_lba_high,
    input wire logic [7:0] sh_device,
    input wire logic [7:0] sh_lba_low_prev,
    input wire logic [7:0] sh_lba_mid_prev,
    input wire logic [7:0] sh_lba_high_prev,
    input wire logic [7:0] sh_count,
    input wire logic [7:0] sh_count_prev,
    input wire logic interface_crc_error,
    input wire logic link_phy_ready_state,
    input wire logic sig_fis_sent,
    input wire logic rx_fis_crc_err,
    input wire logic rx_fis_other_err,
    input wire logic bist_activate,
    input wire logic link_comreset,
    input wire logic soft_reset
);

    elpc_pkg::elpc_top_s s_q;
    elpc_pkg::elpc_top_s s_d;

    logic [elpc_pkg::ELPC_NUM_CNT-1:0] cnt_inc;
    logic [elpc_pkg::ELPC_NUM_CNT*elpc_pkg::ELPC_CNT_W-1:0] cnt_val;
    logic [elpc_pkg::ELPC_NUM_CNT*12-1:0] cnt_code;
    logic cnt_clr;
    logic phy_drop;
    logic [elpc_pkg::ELPC_EVT_USED_BYTES*8-1:0] evt_lo;
    logic [127:0] err_lo;
    logic [7:0] err_cks;
    logic [7:0] evt_cks;
    logic [31:0] rd_word;
    logic addr_ok;
    logic take;

    // ready-to-not-ready edge of the link state
    assign phy_drop = s_q.phy_rdy && !link_phy_ready_state;

    // link resets are deliberately not wired to the counters
    assign cnt_clr = bist_activate || s_q.clr;

    // received inputs come from the host, sent ones go to the host
    assign cnt_inc[0] = interface_crc_error;
    assign cnt_inc[1] = phy_drop;
    assign cnt_inc[2] = sig_fis_sent;
    assign cnt_inc[3] = rx_fis_crc_err;
    assign cnt_inc[4] = rx_fis_other_err;

    assign cnt_code = {elpc_pkg::ELPC_ID_RX_OTHER, elpc_pkg::ELPC_ID_RX_CRC, elpc_pkg::ELPC_ID_SIG_FIS,
                       elpc_pkg::ELPC_ID_PHY_DROP, elpc_pkg::ELPC_ID_INTERFACE_CRC_ERROR};

    genvar gi;
    generate
        for (gi = 0; gi < elpc_pkg::ELPC_NUM_CNT; gi = gi + 1) begin : g_cnt
            elpc_sat_cnt #(
                .W(elpc_pkg::ELPC_CNT_W)
            ) u_cnt (
                .hclk(hclk),
                .hresetn(hresetn),
                .clr(cnt_clr),
                .inc(cnt_inc[gi]),
                .cnt(cnt_val[gi*elpc_pkg::ELPC_CNT_W +: elpc_pkg::ELPC_CNT_W])
            );
            // identifier word then value, little endian, from byte 4
            assign evt_lo[(4+4*gi)*8 +: 16] = {1'b0, elpc_pkg::ELPC_WCODE_16, cnt_code[gi*12 +: 12]};
            assign evt_lo[(6+4*gi)*8 +: 16] = cnt_val[gi*elpc_pkg::ELPC_CNT_W +: elpc_pkg::ELPC_CNT_W];
        end
    endgenerate

    assign evt_lo[31:0] = 32'h0000_0000;
    // end marker identifier and padding word
    assign evt_lo[elpc_pkg::ELPC_EVT_USED_BYTES*8-1 -: 32] = {20'h0_0000, elpc_pkg::ELPC_ID_END};

    assign err_lo = s_q.err_rec;

    // byte sums of the few non-zero bytes; all other bytes are zero
    always_comb begin
        logic [7:0] sum_e;
        logic [7:0] sum_v;
        sum_e = 8'h00;
        sum_v = 8'h00;
        for (int i = 0; i < elpc_pkg::ELPC_ERR_USED_BYTES; i++) begin
            sum_e = sum_e + err_lo[i*8 +: 8];
        end
        for (int i = 0; i < elpc_pkg::ELPC_EVT_USED_BYTES; i++) begin
            sum_v = sum_v + evt_lo[i*8 +: 8];
        end
        err_cks = 8'h00 - sum_e;
        evt_cks = 8'h00 - sum_v;
    end

    // read data for the word held in the data phase
    always_comb begin
        logic [6:0] w;
        w = s_q.pend_word[6:0];
        rd_word = 32'h0000_0000;
        case (s_q.pend_word[9:7])
            3'h0: begin
                if (w == elpc_pkg::ELPC_CKS_WORD) begin
                    rd_word = {err_cks, 24'h00_0000};
                end else if (w < 7'h04) begin
                    rd_word = err_lo[w[1:0]*32 +: 32];
                end else begin
                    rd_word = 32'h0000_0000;
                end
            end
            3'h1: begin
                if (w == elpc_pkg::ELPC_CKS_WORD) begin
                    rd_word = {evt_cks, 24'h00_0000};
                end else if (w < 7'h07) begin
                    rd_word = evt_lo[w[2:0]*32 +: 32];
                end else begin
                    rd_word = 32'h0000_0000;
                end
            end
            3'h2: begin
                if (w == elpc_pkg::ELPC_CTRL_OFS[8:2]) begin
                    rd_word = {31'h0, s_q.clr_on_read};
                end else if (w == elpc_pkg::ELPC_STATUS_OFS[8:2]) begin
                    rd_word = {29'h0, s_q.clr_on_read, s_q.phy_rdy, s_q.err_valid};
                end
            end
            default: begin
                rd_word = 32'h0000_0000;
            end
        endcase
    end

    assign addr_ok = haddr[31:12] == 20'h0_0000;
    assign take = hsel && htrans[1] && hready;

    always_comb begin
        s_d = s_q;
        s_d.clr = 1'b0;
        s_d.resp = 1'b0;
        s_d.phy_rdy = link_phy_ready_state;
        if (take) begin
            s_d.pend = 1'b1;
            s_d.pend_wr = hwrite;
            // unmapped space decodes to an unused word that reads zero
            s_d.pend_word = addr_ok ? haddr[11:2] : 10'h3FF;
            s_d.ready = 1'b0;
        end else if (s_q.pend) begin
            s_d.pend = 1'b0;
            s_d.ready = 1'b1;
            if (s_q.pend_wr) begin
                if (s_q.pend_word == elpc_pkg::ELPC_CTRL_OFS[11:2]) begin
                    s_d.clr_on_read = hwdata[elpc_pkg::ELPC_CTRL_CLR_ON_READ];
                end
            end else begin
                s_d.rdata = rd_word;
                // last word of the event page returned: clear afterwards
                if (s_q.clr_on_read && s_q.pend_word == {3'h1, elpc_pkg::ELPC_CKS_WORD}) begin
                    s_d.clr = 1'b1;
                    s_d.clr_on_read = 1'b0;
                end
            end
        end
        if (err_report) begin
            s_d.err_valid = 1'b1;
            s_d.err_rec = elpc_pkg::ELPC_ERR_REC_RST;
            s_d.err_rec[elpc_pkg::ELPC_NQ_BIT] = non_queued_flag;
            if (!non_queued_flag) begin
                s_d.err_rec[elpc_pkg::ELPC_TAG_LSB +: elpc_pkg::ELPC_TAG_W] = err_tag;
            end
            s_d.err_rec[2*8 +: 8] = sh_status;
            s_d.err_rec[3*8 +: 8] = sh_error;
            s_d.err_rec[4*8 +: 8] = sh_lba_low;
            s_d.err_rec[5*8 +: 8] = sh_lba_mid;
            s_d.err_rec[6*8 +: 8] = sh_lba_high;
            s_d.err_rec[7*8 +: 8] = sh_device;
            s_d.err_rec[8*8 +: 8] = sh_lba_low_prev;
            s_d.err_rec[9*8 +: 8] = sh_lba_mid_prev;
            s_d.err_rec[10*8 +: 8] = sh_lba_high_prev;
            s_d.err_rec[12*8 +: 8] = sh_count;
            s_d.err_rec[13*8 +: 8] = sh_count_prev;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q <= '{pend: 1'b0, pend_wr: 1'b0, pend_word: 10'h000, rdata: elpc_pkg::ELPC_RDATA_RST,
                     ready: 1'b1, resp: 1'b0, clr_on_read: 1'b0, clr: 1'b0, phy_rdy: 1'b0,
                     err_valid: 1'b0, err_rec: elpc_pkg::ELPC_ERR_REC_RST};
        end else begin
            s_q <= s_d;
        end
    end

    assign hrdata = s_q.rdata;
    assign hreadyout = s_q.ready;
    assign hresp = s_q.resp;

    // helper for checks: read completing this cycle
    logic rd_done;
    logic rd_last_q;
    logic [9:0] rd_word_q;
    logic [7:0] err_sum_chk;

    // remembers the data phase that just ended, for the read checks
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_last_q <= 1'b0;
            rd_word_q <= 10'h000;
        end else begin
            rd_last_q <= s_q.pend && !s_q.pend_wr;
            rd_word_q <= s_q.pend_word;
        end
    end

    assign rd_done = s_q.ready && rd_last_q;
    always_comb begin
        err_sum_chk = 8'h00;
        for (int i = 0; i < elpc_pkg::ELPC_ERR_USED_BYTES; i++) begin
            err_sum_chk = err_sum_chk + s_q.err_rec[i*8 +: 8];
        end
    end

    a_tag_capture: assert property (@(posedge hclk) disable iff (!hresetn)
        (err_report && !non_queued_flag) |=> s_q.err_rec[4:0] == $past(err_tag) && !s_q.err_rec[7])
        else $error("queued tag not captured");

    a_nq_flag: assert property (@(posedge hclk) disable iff (!hresetn)
        (err_report && non_queued_flag) |=> s_q.err_rec[7] && s_q.err_rec[4:0] == 5'h00)
        else $error("non-queued flag wrong");

    a_shadow_snap: assert property (@(posedge hclk) disable iff (!hresetn)
        err_report |=> s_q.err_rec[23:16] == $past(sh_status) && s_q.err_rec[111:104] == $past(sh_count_prev)
        && s_q.err_rec[95:88] == 8'h00)
        else $error("shadow snapshot wrong");

    a_err_reserved: assert property (@(posedge hclk) disable iff (!hresetn)
        (rd_done && rd_word_q[9:7] == 3'h0 && rd_word_q[6:0] > 7'h03 && rd_word_q[6:0] < 7'h7F)
        |-> s_q.rdata == 32'h0000_0000)
        else $error("reserved error bytes not zero");

    a_err_checksum: assert property (@(posedge hclk) disable iff (!hresetn)
        (rd_done && rd_word_q == 10'h07F && $stable(s_q.err_rec))
        |-> 8'(err_sum_chk + s_q.rdata[31:24]) == 8'h00 && s_q.rdata[23:0] == 24'h00_0000)
        else $error("error page checksum wrong");

    a_id_word: assert property (@(posedge hclk) disable iff (!hresetn)
        (rd_done && rd_word_q == 10'h081) |-> s_q.rdata[15:0] == 16'h1001)
        else $error("first identifier word wrong");

    a_end_marker: assert property (@(posedge hclk) disable iff (!hresetn)
        (rd_done && rd_word_q[9:7] == 3'h1 && rd_word_q[6:0] == 7'h06) |-> s_q.rdata == 32'h0000_0000)
        else $error("end marker word not zero");

    a_read_clear: assert property (@(posedge hclk) disable iff (!hresetn)
        (s_q.pend && !s_q.pend_wr && s_q.clr_on_read && s_q.pend_word == 10'h0FF)
        |=> s_q.clr ##1 (cnt_val == '0 || $past(cnt_inc) != '0))
        else $error("counters not cleared after read");

    a_reset_keep: assert property (@(posedge hclk) disable iff (!hresetn)
        ((link_comreset || soft_reset) && !cnt_clr && cnt_inc == '0) |=> $stable(cnt_val))
        else $error("link reset disturbed counters");

    a_phy_drop: assert property (@(posedge hclk) disable iff (!hresetn)
        (s_q.phy_rdy && !link_phy_ready_state && !cnt_clr && cnt_val[31:16] != 16'hFFFF)
        |=> cnt_val[31:16] == $past(cnt_val[31:16]) + 16'h0001)
        else $error("phy drop not counted");

    a_interface_crc_error_count: assert property (@(posedge hclk) disable iff (!hresetn)
        (interface_crc_error && !cnt_clr && cnt_val[15:0] != 16'hFFFF)
        |=> cnt_val[15:0] == $past(cnt_val[15:0]) + 16'h0001)
        else $error("crc-failed command not counted");

    a_sig_count: assert property (@(posedge hclk) disable iff (!hresetn)
        (sig_fis_sent && !cnt_clr && cnt_val[47:32] != 16'hFFFF)
        |=> cnt_val[47:32] == $past(cnt_val[47:32]) + 16'h0001)
        else $error("signature fis not counted");

    a_rx_crc_count: assert property (@(posedge hclk) disable iff (!hresetn)
        (rx_fis_crc_err && !cnt_clr && cnt_val[63:48] != 16'hFFFF)
        |=> cnt_val[63:48] == $past(cnt_val[63:48]) + 16'h0001)
        else $error("received crc error not counted");

    a_rx_other_count: assert property (@(posedge hclk) disable iff (!hresetn)
        (rx_fis_other_err && !cnt_clr && cnt_val[79:64] != 16'hFFFF)
        |=> cnt_val[79:64] == $past(cnt_val[79:64]) + 16'h0001)
        else $error("received other error not counted");

    a_bist_clear: assert property (@(posedge hclk) disable iff (!hresetn)
        bist_activate |=> (cnt_val == '0 || $past(cnt_inc) != '0))
        else $error("bist activate did not clear counters");

    a_evt_head: assert property (@(posedge hclk) disable iff (!hresetn)
        (rd_done && rd_word_q == 10'h080) |-> s_q.rdata == 32'h0000_0000)
        else $error("event page head not zero");

    a_evt_tail: assert property (@(posedge hclk) disable iff (!hresetn)
        (rd_done && rd_word_q[9:7] == 3'h1 && rd_word_q[6:0] > 7'h06 && rd_word_q[6:0] < 7'h7F)
        |-> s_q.rdata == 32'h0000_0000)
        else $error("event page tail not zero");

    a_bus_okay: assert property (@(posedge hclk) disable iff (!hresetn)
        take |=> !hreadyout ##1 hreadyout && !hresp)
        else $error("bus answer timing wrong");

endmodule : elpc_top

//--- tb/elpc_host_model.sv
/*
 * elpc_host_model: host-side AHB-Lite master that fetches log page words.
 * Assumes one slave whose hreadyout is fed back as hready.
 */
`timescale 1ns/1ps
module elpc_host_model (
    input wire logic hclk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end

    // one single word transfer; ok drops when the slave never answers
    task xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd, output bit ok);
        int n;
        n = 0;
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        hsize <= 3'h2;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 20);
        htrans <= 2'h0;
        hwdata <= wd;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 40);
        rd = hrdata;
        ok = (n < 40);
        // released data is inverted so a stale value cannot pass for a write
        hwdata <= ~wd;
    endtask : xfer
endmodule : elpc_host_model

//--- tb/elpc_top_tb.sv
/*
 * elpc_top_tb: checks both log pages against a byte model of each page.
 * Assumes the host model as bus master and a 250 MHz clock.
 */
`timescale 1ns/1ps
module elpc_top_tb;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic err_report = 1'b0;
    logic nonq = 1'b0;
    logic [4:0] err_tag = 5'h0;
    logic [10:0][7:0] sh = '0;
    logic [4:0] ev = 5'h0;
    logic phy = 1'b0;
    logic bist = 1'b0;
    logic comrst = 1'b0;
    logic srst = 1'b0;
    int fails = 0;
    int check_count = 0;
    logic [7:0] pg [512];
    logic [7:0] m_err [14];
    int cnt [5];
    logic [11:0] ids [5] = '{12'h001, 12'h009, 12'h00A, 12'h00B, 12'h00D};
    logic [31:0] rd;
    bit ok;

    always #2 hclk = ~hclk;

    elpc_host_model host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

    elpc_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .err_report(err_report), .non_queued_flag(nonq),
        .err_tag(err_tag), .sh_status(sh[0]), .sh_error(sh[1]), .sh_lba_low(sh[2]), .sh_lba_mid(sh[3]),
        .sh_lba_high(sh[4]), .sh_device(sh[5]), .sh_lba_low_prev(sh[6]), .sh_lba_mid_prev(sh[7]),
        .sh_lba_high_prev(sh[8]), .sh_count(sh[9]), .sh_count_prev(sh[10]), .interface_crc_error(ev[0]),
        .link_phy_ready_state(phy), .sig_fis_sent(ev[2]), .rx_fis_crc_err(ev[3]), .rx_fis_other_err(ev[4]),
        .bist_activate(bist), .link_comreset(comrst), .soft_reset(srst));

    task finish_test();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : finish_test

    task chk(input string what, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", what, e, g);
            fails++;
        end
    endtask : chk

    task rw(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        host.xfer(wr, a, wd, rd, ok);
        chk("hresp", 32'h0000_0000, {31'h0, hresp});
        if (!ok) begin
            fails++;
            finish_test();
        end
    endtask : rw

    task cks();
        logic [7:0] s;
        s = 8'h00;
        for (int i = 0; i < 511; i++) begin
            s = s + pg[i];
        end
        pg[511] = -s;
    endtask : cks

    task exp_err();
        for (int i = 0; i < 512; i++) begin
            pg[i] = (i < 14) ? m_err[i] : 8'h00;
        end
        cks();
    endtask : exp_err

    task exp_evt();
        logic [15:0] id;
        for (int i = 0; i < 512; i++) begin
            pg[i] = 8'h00;
        end
        for (int i = 0; i < 5; i++) begin
            id = {1'b0, 3'h1, ids[i]};
            pg[4 + 4 * i] = id[7:0];
            pg[5 + 4 * i] = id[15:8];
            pg[6 + 4 * i] = 8'(cnt[i]);
            pg[7 + 4 * i] = 8'(cnt[i] >> 8);
        end
        cks();
    endtask : exp_evt

    task page(input logic [11:0] base);
        logic [31:0] a;
        for (int w = 0; w < 128; w++) begin
            a = {20'h0, base} + 32'(4 * w);
            rw(1'b0, a, 32'h0);
            chk($sformatf("word %h", a), {pg[4 * w + 3], pg[4 * w + 2], pg[4 * w + 1], pg[4 * w]}, rd);
        end
    endtask : page

    task report(input logic nq_in);
        logic [10:0][7:0] v;
        logic [4:0] t;
        v = 88'({$urandom, $urandom, $urandom});
        t = 5'($urandom);
        @(posedge hclk);
        sh <= v;
        err_tag <= t;
        nonq <= nq_in;
        err_report <= 1'b1;
        @(posedge hclk);
        err_report <= 1'b0;
        sh <= ~v;
        m_err[0] = {nq_in, 2'b00, nq_in ? 5'h00 : t};
        m_err[1] = 8'h00;
        for (int i = 0; i < 9; i++) begin
            m_err[2 + i] = v[i];
        end
        m_err[11] = 8'h00;
        m_err[12] = v[9];
        m_err[13] = v[10];
    endtask : report

    // resets of the link and of software ride along with every event
    task pulse(input int i);
        @(posedge hclk);
        if (i == 1) begin
            phy <= 1'b1;
        end else begin
            ev[i] <= 1'b1;
        end
        comrst <= 1'b1;
        srst <= 1'b1;
        @(posedge hclk);
        ev <= 5'h0;
        phy <= 1'b0;
        comrst <= 1'b0;
        srst <= 1'b0;
        @(posedge hclk);
        if (cnt[i] < 65535) begin
            cnt[i]++;
        end
    endtask : pulse

    task power_up();
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        cnt = '{5{0}};
        m_err = '{14{8'h00}};
    endtask : power_up

    task done(input string name);
        $display("test %s done", name);
    endtask : done

    initial begin
        void'($urandom(32'h198C));
        power_up();
        exp_err();
        page(12'h000);
        exp_evt();
        page(12'h200);
        done("reset values");
        report(1'b0);
        exp_err();
        page(12'h000);
        report(1'b1);
        exp_err();
        page(12'h000);
        done("error record");
        for (int k = 0; k < 40; k++) begin
            pulse($urandom_range(0, 4));
        end
        exp_evt();
        page(12'h200);
        done("event counts");
        @(posedge hclk);
        bist <= 1'b1;
        @(posedge hclk);
        bist <= 1'b0;
        cnt = '{5{0}};
        pulse(3);
        exp_evt();
        page(12'h200);
        done("bist clear");
        @(posedge hclk);
        ev[0] <= 1'b1;
        repeat (65540) @(posedge hclk);
        ev[0] <= 1'b0;
        cnt[0] = 65535;
        pulse(2);
        rw(1'b1, 32'h400, 32'h1);
        rw(1'b0, 32'h404, 32'h0);
        chk("status armed", 32'h5, rd);
        exp_evt();
        page(12'h200);
        repeat (2) @(posedge hclk);
        cnt = '{5{0}};
        exp_evt();
        page(12'h200);
        rw(1'b0, 32'h404, 32'h0);
        chk("status disarmed", 32'h1, rd);
        done("saturate and clear on read");
        rw(1'b1, 32'h800, 32'hA5A5_A5A5);
        rw(1'b1, 32'h204, 32'h5A5A_5A5A);
        rw(1'b0, 32'h800, 32'h0);
        chk("unmapped word", 32'h0, rd);
        pulse(4);
        pulse(0);
        power_up();
        exp_evt();
        page(12'h200);
        exp_err();
        page(12'h000);
        done("power cycle");
        finish_test();
    end
endmodule : elpc_top_tb
